// *** acms_sequencer.sv ***
// Conversion mode sequencer of a multichannel converter, with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "acms_params.svh"

// Behaviour
// - Sweep mode stops converting once the FIFO holds the threshold count.
// - Sweep at threshold: only register accesses act; conversions ignored.
// - Repeat sweep at threshold: a conversion clears the FIFO and restarts sweep.
// - Single shot results bypass the FIFO; repeat mode results go into it.
// - Repeat mode needs a fresh channel selection once the FIFO reaches the threshold count.
// - Each sweep trigger below the threshold count converts the next sequence channel; reads return in order.
// - Repeat sweep after readout converts the sequence again from its first channel.
module acms_sequencer #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8,
	parameter int CONV_EDGES = `ACMS_CONV_SCLK_EDGES
) (
	// Clock, reset and enable
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Link pins
	input wire logic link_sclk,
	input wire logic cs_n,
	input wire logic conversion_start_pin_n,
	// Converter core
	input wire logic [WIDTH-1:0] adc_code,
	output logic [2:0] adc_channel,
	output logic conv_busy,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int CW = $clog2(DEPTH+1);
	localparam int NW = $clog2(CONV_EDGES);

	acms_fifo_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fifo ();

	acms_result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.fifo(fifo.store)
	);

	// ==========================================================
	// Pin synchronisers; only the second and third stages are looked at.
	logic [2:0] sclk_q, cs_q, cst_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 3'h0;
			cs_q <= 3'h7;
			cst_q <= 3'h7;
		end else if (clk_en) begin
			sclk_q <= {sclk_q[1:0], link_sclk};
			cs_q <= {cs_q[1:0], cs_n};
			cst_q <= {cst_q[1:0], conversion_start_pin_n};
		end
	end
	logic sclk_rise, pin_trig;
	assign sclk_rise = sclk_q[1] && !sclk_q[2];
	assign pin_trig = (!cs_q[1] && cs_q[2]) || (!cst_q[1] && cst_q[2]);

	// ==========================================================
	// AXI4-Lite slave
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] awaddr_q, awaddr_d, araddr;
	logic [31:0] wdata_q, wdata_d, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic wr_do, rd_do, wr_hit;

	assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
	assign rd_do = s_axi_arvalid && s_axi_arready;
	assign araddr = s_axi_araddr;
	assign wr_hit = (awaddr_q == `ACMS_OFS_CONFIG) || (awaddr_q == `ACMS_OFS_COMMAND);

	// ==========================================================
	// Sequencer state
	acms_pkg::acms_state_type state_q, state_d;
	logic [31:0] cfg_q, cfg_d;
	logic [2:0] sel_ch_q, sel_ch_d, pos_q, pos_d, ch_q, ch_d;
	logic sel_ok_q, sel_ok_d, direct_ok_q, direct_ok_d;
	logic [WIDTH-1:0] direct_q, direct_d;
	logic [NW-1:0] edge_q, edge_d;
	acms_pkg::acms_mode_type mode;
	logic [CW-1:0] thr;
	logic [2:0] seq_ch;
	logic at_thr, cfg_wr, cmd_wr, trig, done, start, pop_rd;

	assign mode = acms_pkg::acms_mode_type'(cfg_q[`ACMS_CFG_MODE_LSB +: 2]);
	assign thr = CW'(cfg_q[`ACMS_CFG_THR_LSB +: 3]) + 1'b1;
	assign seq_ch = cfg_q[`ACMS_CFG_SEQ_LSB + 3*pos_q +: 3];
	assign at_thr = fifo.count >= thr;
	assign cfg_wr = wr_do && (awaddr_q == `ACMS_OFS_CONFIG);
	assign cmd_wr = wr_do && (awaddr_q == `ACMS_OFS_COMMAND);
	assign trig = pin_trig || (cmd_wr && wdata_q[`ACMS_CMD_CONVERT_BIT]);
	assign done = (state_q == acms_pkg::ACMS_ST_CONV) && sclk_rise
		&& (edge_q == NW'(CONV_EDGES-1));
	assign pop_rd = rd_do && (araddr == `ACMS_OFS_FIFO);

	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		sel_ch_d = sel_ch_q;
		sel_ok_d = sel_ok_q;
		pos_d = pos_q;
		ch_d = ch_q;
		edge_d = edge_q;
		direct_d = direct_q;
		direct_ok_d = direct_ok_q;
		start = 1'b0;
		fifo.flush = 1'b0;
		fifo.push = 1'b0;
		fifo.push_data = adc_code;
		fifo.pop = pop_rd;
		if (rd_do && (araddr == `ACMS_OFS_DIRECT)) begin
			direct_ok_d = 1'b0;
		end
		if (cfg_wr) begin
			// Reconfiguring dumps stored results and needs a new channel selection.
			if (wstrb_q[0]) cfg_d[7:0] = wdata_q[7:0];
			if (wstrb_q[1]) cfg_d[15:8] = wdata_q[15:8];
			if (wstrb_q[2]) cfg_d[23:16] = wdata_q[23:16];
			if (wstrb_q[3]) cfg_d[31:24] = wdata_q[31:24];
			fifo.flush = 1'b1;
			pos_d = 3'h0;
			sel_ok_d = 1'b0;
			state_d = acms_pkg::ACMS_ST_IDLE;
		end else begin
			if (cmd_wr && wdata_q[`ACMS_CMD_SELECT_BIT]) begin
				sel_ch_d = wdata_q[`ACMS_CMD_CH_LSB +: 3];
				sel_ok_d = 1'b1;
			end
			if (state_q == acms_pkg::ACMS_ST_IDLE && trig) begin
				unique case (mode)
					acms_pkg::ACMS_MODE_SINGLE: begin
						start = sel_ok_q;
						ch_d = sel_ch_q;
					end
					acms_pkg::ACMS_MODE_REPEAT: begin
						start = sel_ok_q && !at_thr;
						ch_d = sel_ch_q;
					end
					acms_pkg::ACMS_MODE_SWEEP: begin
						start = !at_thr;
						ch_d = seq_ch;
						pos_d = start ? ((pos_q + 3'h1 == thr[2:0]) ? 3'h0 : pos_q + 3'h1) : pos_q;
					end
					acms_pkg::ACMS_MODE_RSWEEP: begin
						start = 1'b1;
						fifo.flush = at_thr;
						ch_d = at_thr ? cfg_q[`ACMS_CFG_SEQ_LSB +: 3] : seq_ch;
						if (at_thr) begin
							pos_d = (thr[2:0] == 3'h1) ? 3'h0 : 3'h1;
						end else begin
							pos_d = (pos_q + 3'h1 == thr[2:0]) ? 3'h0 : pos_q + 3'h1;
						end
					end
				endcase
				if (start) begin
					state_d = acms_pkg::ACMS_ST_CONV;
					edge_d = '0;
				end else begin
					ch_d = ch_q;
				end
			end else if (state_q == acms_pkg::ACMS_ST_CONV && sclk_rise) begin
				edge_d = edge_q + 1'b1;
				if (done) begin
					state_d = acms_pkg::ACMS_ST_IDLE;
					if (mode == acms_pkg::ACMS_MODE_SINGLE) begin
						direct_d = adc_code;
						direct_ok_d = 1'b1;
					end else begin
						fifo.push = 1'b1;
						// A filled repeat FIFO forces a fresh channel selection.
						if (mode == acms_pkg::ACMS_MODE_REPEAT && fifo.count + 1'b1 >= thr) begin
							sel_ok_d = 1'b0;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= acms_pkg::ACMS_ST_IDLE;
			cfg_q <= `ACMS_CFG_RESET;
			sel_ch_q <= 3'h0;
			sel_ok_q <= 1'b0;
			pos_q <= 3'h0;
			ch_q <= 3'h0;
			edge_q <= '0;
			direct_q <= '0;
			direct_ok_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			sel_ch_q <= sel_ch_d;
			sel_ok_q <= sel_ok_d;
			pos_q <= pos_d;
			ch_q <= ch_d;
			edge_q <= edge_d;
			direct_q <= direct_d;
			direct_ok_q <= direct_ok_d;
		end
	end

	assign adc_channel = ch_q;
	assign conv_busy = (state_q == acms_pkg::ACMS_ST_CONV);

	// ==========================================================
	// Bus channel next values
	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_do) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? `ACMS_RESP_OKAY : `ACMS_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = !aw_full_d && !bvalid_d;
		wready_d = !w_full_d && !bvalid_d;
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (rd_do) begin
			rvalid_d = 1'b1;
			rresp_d = `ACMS_RESP_OKAY;
			unique case (araddr)
				`ACMS_OFS_CONFIG: rdata_d = cfg_q;
				`ACMS_OFS_STATUS: rdata_d = {16'h0000, 3'h0, pos_q, CW'(fifo.count), 1'b0,
					at_thr, sel_ok_q, conv_busy, mode};
				`ACMS_OFS_FIFO: rdata_d = (fifo.count != '0) ? 32'(fifo.head) : 32'h0000_0000;
				`ACMS_OFS_DIRECT: rdata_d = {direct_ok_q, 15'h0000, 16'(direct_q)};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = `ACMS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (clk_en) begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
		end
	end

	// ==========================================================
	// Checks
	sequence s_idle_trig;
		clk_en && !cfg_wr && state_q == acms_pkg::ACMS_ST_IDLE && trig;
	endsequence
	sequence s_restarted;
		conv_busy && fifo.count == '0 && adc_channel == $past(cfg_q[10:8]);
	endsequence

	chk_sweep_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == acms_pkg::ACMS_MODE_SWEEP && at_thr && !conv_busy && !cfg_wr |=> !conv_busy)
		else $error("sweep converted past threshold");
	chk_sweep_ignore: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_idle_trig and mode == acms_pkg::ACMS_MODE_SWEEP && at_thr
		|=> fifo.count <= $past(fifo.count) && adc_channel == $past(adc_channel))
		else $error("sweep conversion not ignored at threshold");
	chk_rsweep_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_idle_trig and mode == acms_pkg::ACMS_MODE_RSWEEP && at_thr |=> s_restarted)
		else $error("repeat sweep did not restart");
	chk_single_direct: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && done && !cfg_wr && mode == acms_pkg::ACMS_MODE_SINGLE
		|=> direct_ok_q && direct_q == $past(adc_code) && fifo.count == $past(fifo.count))
		else $error("single shot result misplaced");
	chk_repeat_push: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && done && !cfg_wr && !pop_rd && mode == acms_pkg::ACMS_MODE_REPEAT
		|=> fifo.count == $past(fifo.count) + 1'b1)
		else $error("repeat result not stored");
	chk_repeat_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode == acms_pkg::ACMS_MODE_REPEAT && !sel_ok_q && !conv_busy |=> !conv_busy)
		else $error("repeat converted without a channel selection");
	chk_sweep_order: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_idle_trig and mode == acms_pkg::ACMS_MODE_SWEEP && !at_thr
		|=> conv_busy && adc_channel == $past(seq_ch))
		else $error("sweep channel out of order");
	chk_mode_flush: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && cfg_wr ##1 mode != $past(mode) |-> fifo.count == '0 && pos_q == 3'h0)
		else $error("mode change kept old results");
	chk_conv_length: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(conv_busy) |-> conv_busy [*8])
		else $error("conversion ended too early");
endmodule

// *** acms_params.svh ***
// Constants of the conversion mode sequencer: offsets, fields, reset values and counts.
`ifndef ACMS_PARAMS_SVH
`define ACMS_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define ACMS_OFS_CONFIG 8'h00
`define ACMS_OFS_COMMAND 8'h04
`define ACMS_OFS_STATUS 8'h08
`define ACMS_OFS_FIFO 8'h0c
`define ACMS_OFS_DIRECT 8'h10

// ==========================================================
// Configuration register fields
`define ACMS_CFG_MODE_LSB 0
`define ACMS_CFG_THR_LSB 4
`define ACMS_CFG_SEQ_LSB 8
`define ACMS_CFG_RESET 32'h0000_0000

// ==========================================================
// Command register fields
`define ACMS_CMD_CH_LSB 0
`define ACMS_CMD_SELECT_BIT 8
`define ACMS_CMD_CONVERT_BIT 9

// ==========================================================
// Bus answers and timing
`define ACMS_RESP_OKAY 2'h0
`define ACMS_RESP_SLVERR 2'h2
`define ACMS_CONV_SCLK_EDGES 14

`endif

// *** acms_pkg.sv ***
// Types shared by the conversion mode sequencer files.
package acms_pkg;
	typedef enum logic [1:0] {
		ACMS_MODE_SINGLE,
		ACMS_MODE_REPEAT,
		ACMS_MODE_SWEEP,
		ACMS_MODE_RSWEEP
	} acms_mode_type;

	typedef enum logic {
		ACMS_ST_IDLE,
		ACMS_ST_CONV
	} acms_state_type;
endpackage

// *** acms_fifo_if.sv ***
// Connection between the sequencer and its result store.
`timescale 1ns/1ns
interface acms_fifo_if #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
);
	logic push;
	logic [WIDTH-1:0] push_data;
	logic pop;
	logic flush;
	logic [WIDTH-1:0] head;
	logic [$clog2(DEPTH+1)-1:0] count;

	modport producer(output push, output push_data, output pop, output flush,
		input head, input count);
	modport store(input push, input push_data, input pop, input flush,
		output head, output count);
endinterface

// *** acms_result_fifo.sv ***
// Result store: flip-flop FIFO with flush, pushed by conversions and popped by reads.
`timescale 1ns/1ns
module acms_result_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Sequencer side
	acms_fifo_if.store fifo
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	// ==========================================================
	// Next state
	always_comb begin
		mem_d = mem_q;
		rd_d = rd_q;
		wr_d = wr_q;
		cnt_d = cnt_q;
		do_push = fifo.push && (cnt_q != CW'(DEPTH));
		do_pop = fifo.pop && (cnt_q != '0);
		if (fifo.flush) begin
			rd_d = '0;
			wr_d = '0;
			cnt_d = '0;
		end else begin
			if (do_push) begin
				mem_d[wr_q] = fifo.push_data;
				wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			mem_q <= mem_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
		end
	end

	assign fifo.head = mem_q[rd_q];
	assign fifo.count = cnt_q;
endmodule

// *** acms_host_model.sv ***
// Host serial port model: frames a conversion with chip select or start pin and link clock.
`timescale 1ns/1ns
module acms_host_model #(
	parameter int EDGES = 4
) (
	// Clock and request
	input wire logic sys_clk,
	input wire logic go,
	input wire logic use_start,
	// Link pins and frame done flag
	output logic cs_n,
	output logic conversion_start_pin_n,
	output logic link_sclk,
	output logic done
);
	// ==========================================================
	// Frame generator
	// The link clock stands low between frames, so a conversion can only
	// finish inside a frame, as on the real serial port.
	initial begin
		cs_n = 1'b1;
		conversion_start_pin_n = 1'b1;
		link_sclk = 1'b0;
		done = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (go) begin
				#7;
				if (use_start) conversion_start_pin_n = 1'b0;
				else cs_n = 1'b0;
				repeat (EDGES + 2) begin
					#80 link_sclk = 1'b1;
					#80 link_sclk = 1'b0;
				end
				cs_n = 1'b1;
				conversion_start_pin_n = 1'b1;
				@(posedge sys_clk);
				done <= 1'b1;
				@(posedge sys_clk);
				done <= 1'b0;
			end
		end
	end
endmodule

// *** acms_sequencer_bench.sv ***
// Self-checking bench of the conversion mode sequencer over its register bus and link pins.
`timescale 1ns/1ns
`include "acms_params.svh"
module acms_sequencer_bench;
	localparam int EDGES = 4;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0;
	logic use_start = 1'b0;
	logic cs_n, start_n, sclk, done;
	logic [11:0] adc_code = 12'h000;
	logic [2:0] adc_channel;
	logic conv_busy;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, v;
	logic [1:0] r;
	logic busy_seen = 1'b0;
	int fail_count = 0;
	int n_tests = 0;

	always #10 sys_clk = ~sys_clk;
	// The code carries the converted channel, so stored results reveal their order.
	always @(posedge sys_clk) adc_code <= {4'ha, 5'h00, adc_channel};

	acms_host_model #(.EDGES(EDGES)) acms_host_model_inst (.sys_clk(sys_clk), .go(go),
		.use_start(use_start), .cs_n(cs_n), .conversion_start_pin_n(start_n),
		.link_sclk(sclk), .done(done));

	acms_sequencer #(.CONV_EDGES(EDGES)) acms_sequencer_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .clk_en(1'b1), .link_sclk(sclk), .cs_n(cs_n),
		.conversion_start_pin_n(start_n), .adc_code(adc_code), .adc_channel(adc_channel),
		.conv_busy(conv_busy), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ==========================================================
	// Checking and closing
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic timed_out();
		fail_count++;
		end_of_test();
	endtask

	// ==========================================================
	// Register bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		bit aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
			if (bvalid) break;
		end
		if (n == 200) timed_out();
		rs = bresp;
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 200) timed_out();
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, `ACMS_RESP_OKAY});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v, r);
		chk(v, exp);
	endtask

	// Reads the result count from the status word.
	task automatic count_chk(input logic [31:0] exp);
		rd(`ACMS_OFS_STATUS, v, r);
		chk({28'h0, v[9:6]}, exp);
	endtask

	// One host frame; a refused trigger simply leaves no result behind.
	task automatic conv(input logic pin);
		int n;
		busy_seen = 1'b0;
		use_start <= pin;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		for (n = 0; n < 400 && !done; n++) begin
			@(posedge sys_clk);
			if (conv_busy) busy_seen = 1'b1;
		end
		if (n == 400) timed_out();
		@(posedge sys_clk);
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk(`ACMS_OFS_CONFIG, `ACMS_CFG_RESET);
		rd(8'h14, v, r);
		chk({30'h0, r}, {30'h0, `ACMS_RESP_SLVERR});
		chk(v, 32'h0000_0000);
		wr(`ACMS_OFS_STATUS, 32'h0000_ffff, r);
		chk({30'h0, r}, {30'h0, `ACMS_RESP_SLVERR});
		// Single shot: no conversion before a channel is chosen, then a direct result.
		wr_ok(`ACMS_OFS_CONFIG, 32'h0000_0000);
		conv(1'b0);
		chk({31'h0, busy_seen}, 32'h0000_0000);
		rd_chk(`ACMS_OFS_DIRECT, 32'h0000_0000);
		wr_ok(`ACMS_OFS_COMMAND, 32'h0000_0105);
		conv(1'b1);
		chk({31'h0, busy_seen}, 32'h0000_0001);
		rd_chk(`ACMS_OFS_DIRECT, 32'h8000_0a05);
		count_chk(32'h0000_0000);
		// Repeat with a threshold of two, both trigger pins.
		wr_ok(`ACMS_OFS_CONFIG, 32'h0000_0011);
		wr_ok(`ACMS_OFS_COMMAND, 32'h0000_0103);
		conv(1'b0);
		conv(1'b1);
		count_chk(32'h0000_0002);
		conv(1'b0);
		count_chk(32'h0000_0002);
		rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a03);
		rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a03);
		conv(1'b0);
		chk({31'h0, busy_seen}, 32'h0000_0000);
		count_chk(32'h0000_0000);
		wr_ok(`ACMS_OFS_COMMAND, 32'h0000_0102);
		conv(1'b1);
		rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a02);
		// Sweep over channels 1, 2, 3 with a threshold of three.
		wr_ok(`ACMS_OFS_CONFIG, 32'h0000_d122);
		repeat (4) conv(1'b0);
		chk({31'h0, busy_seen}, 32'h0000_0000);
		rd(`ACMS_OFS_STATUS, v, r);
		chk({28'h0, v[9:6]}, 32'h0000_0003);
		chk({31'h0, v[4]}, 32'h0000_0001);
		for (int k = 1; k <= 3; k++) rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a00 + k);
		conv(1'b1);
		rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a01);
		conv(1'b0);
		wr_ok(`ACMS_OFS_CONFIG, 32'h0000_d123);
		count_chk(32'h0000_0000);
		// Repeat sweep: a trigger at threshold flushes and restarts the sequence.
		repeat (3) conv(1'b0);
		count_chk(32'h0000_0003);
		conv(1'b1);
		rd(`ACMS_OFS_STATUS, v, r);
		chk({31'h0, v[4]}, 32'h0000_0000);
		wr_ok(`ACMS_OFS_CONFIG, 32'h0000_d123);
		repeat (3) conv(1'b0);
		for (int k = 1; k <= 3; k++) rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a00 + k);
		conv(1'b1);
		rd_chk(`ACMS_OFS_FIFO, 32'h0000_0a01);
		end_of_test();
	end
endmodule
